// ### pkg/ocdu_params.svh
// constants for the ones'-complement divide unit
// Behaviour
// - dividend holds up to 59 magnitude bits; divisor may have one bit
// - quotient word is 30 bits; overflow when quotient needs over 29 bits
// - overflow final quotient: +0 for unlike signs, -0 for like signs
// - overflow quotient is -0 when the skip test is made
// - no overflow when dividend has no bit above divisor msb plus 28
// - overflow always when dividend has a bit at divisor msb plus 30
// - dividend msb at divisor msb plus 29: decided by actual quotient size
// - overflow, both positive: remainder is low 30 bits of sum
// - overflow, both negative: remainder is low 30 bits of magnitude sum
// - overflow, +dividend -divisor: magnitude sum, complemented finally
// - overflow, -dividend +divisor: magnitude sum, complemented finally
// - skip select: none, unconditional, or on overflow
// - skip select also offers skip when no overflow occurred
// - skip selects on remainder zero, nonzero, positive, negative
// - zero dividend, unlike signs: final -0 results, +0 at skip test
// - divide magnitudes; complement results if signs differ
// - skip tests look at results before final sign correction
`ifndef OCDU_PARAMS_SVH
`define OCDU_PARAMS_SVH
`define OCDU_WORD_W  30
`define OCDU_DVD_W   60
`define OCDU_STEPS   29
`define OCDU_CNT_W   5
`define OCDU_NEG_ZERO 30'h3fffffff
`define OCDU_POS_ZERO 30'h00000000
`define OCDU_SIGN_BIT 29
`endif

// ### pkg/ocdu_pkg.sv
// types for the ones'-complement divide unit
package ocdu_pkg;
  typedef enum logic [2:0] {
    OCDU_SKIP_NONE          = 3'h0,
    OCDU_SKIP_ALWAYS        = 3'h1,
    OCDU_SKIP_ON_OVERFLOW   = 3'h2,
    OCDU_SKIP_WHEN_NO_OVERFLOW = 3'h3,
    OCDU_SKIP_ACC_ZERO      = 3'h4,
    OCDU_SKIP_ACC_NONZERO   = 3'h5,
    OCDU_SKIP_ACC_POSITIVE  = 3'h6,
    OCDU_SKIP_ACC_NEGATIVE  = 3'h7
  } ocdu_skip_t;

  typedef enum logic [1:0] {
    OCDU_IDLE,
    OCDU_PREP,
    OCDU_DIVIDE,
    OCDU_FINISH
  } ocdu_state_t;
endpackage

// ### rtl/ocdu_divide_unit.sv
// ones'-complement 60-by-30-bit divide datapath with skip evaluation
`timescale 1ns/100ps
`include "ocdu_params.svh"

module ocdu_divide_unit (
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    start_i,
  input  wire logic [`OCDU_WORD_W-1:0] rem_in_i,
  input  wire logic [`OCDU_WORD_W-1:0] quot_in_i,
  input  wire logic [`OCDU_WORD_W-1:0] operand_i,
  input  wire logic [2:0]              skip_sel_i,
  output logic                         busy_o,
  output logic                         done_o,
  output logic                         overflow_o,
  output logic                         skip_o,
  output logic [`OCDU_WORD_W-1:0]      quot_o,
  output logic [`OCDU_WORD_W-1:0]      rem_o
);

  ocdu_pkg::ocdu_state_t     state_q;
  logic [`OCDU_DVD_W-1:0]    dvd_raw_q;
  logic [`OCDU_WORD_W-1:0]   dvs_raw_q;
  ocdu_pkg::ocdu_skip_t      sel_q;
  logic [`OCDU_WORD_W-1:0]   dvs_q;
  logic [`OCDU_STEPS-1:0]    dvd_lo_q;
  logic [`OCDU_WORD_W-1:0]   rem_q;
  logic [`OCDU_WORD_W-1:0]   quo_q;
  logic                      mix_q;
  logic                      ovf_q;
  logic [`OCDU_CNT_W-1:0]    cnt_q;

  logic [`OCDU_DVD_W-1:0]    dvd_mag;
  logic [`OCDU_WORD_W-1:0]   dvs_mag;
  logic                      ovf_d;
  logic [`OCDU_WORD_W-1:0]   ovf_rem;
  logic [`OCDU_WORD_W-1:0]   shifted;
  logic                      fits;
  logic                      acc_zero;
  logic                      skip_d;
  logic [`OCDU_WORD_W:0]     dvd_top;
  logic [`OCDU_WORD_W:0]     dvs_wide;
  logic                      below_n28;
  logic                      from_n30;

  // operands made positive before dividing
  always_comb begin
    dvd_mag = dvd_raw_q[`OCDU_DVD_W-1] ? ~dvd_raw_q : dvd_raw_q;
    dvs_mag = dvs_raw_q[`OCDU_SIGN_BIT] ? ~dvs_raw_q : dvs_raw_q;
  end

  // quotient exceeds 29 bits exactly when the dividend's upper part reaches
  // the divisor; this one compare covers every msb-position case
  always_comb begin
    ovf_d = (dvs_mag == `OCDU_POS_ZERO) ||
            (dvd_mag[`OCDU_DVD_W-1:`OCDU_STEPS] >=
             {1'b0, dvs_mag});
  end

  // magnitude sum gives all four observed sign cases at the skip test
  always_comb begin
    ovf_rem = dvd_mag[`OCDU_WORD_W-1:0] +
              dvs_mag;
  end

  // one restoring step; rem_q < divisor so the shift cannot lose a bit
  always_comb begin
    shifted = {rem_q[`OCDU_WORD_W-2:0], dvd_lo_q[`OCDU_STEPS-1]};
    fits    = shifted >= dvs_q;
  end

  // skip tests use magnitude results, before final correction
  always_comb begin
    acc_zero = (rem_q == `OCDU_POS_ZERO) || (rem_q == `OCDU_NEG_ZERO);
    unique case (sel_q)
      ocdu_pkg::OCDU_SKIP_NONE:             skip_d = 1'b0;
      ocdu_pkg::OCDU_SKIP_ALWAYS:           skip_d = 1'b1;
      ocdu_pkg::OCDU_SKIP_ON_OVERFLOW:      skip_d = ovf_q;
      ocdu_pkg::OCDU_SKIP_WHEN_NO_OVERFLOW: skip_d = !ovf_q;
      ocdu_pkg::OCDU_SKIP_ACC_ZERO:
        skip_d = acc_zero;
      ocdu_pkg::OCDU_SKIP_ACC_NONZERO:
        skip_d = !acc_zero;
      ocdu_pkg::OCDU_SKIP_ACC_POSITIVE:
        skip_d = !rem_q[`OCDU_SIGN_BIT];
      ocdu_pkg::OCDU_SKIP_ACC_NEGATIVE:
        skip_d = rem_q[`OCDU_SIGN_BIT];
    endcase
  end

  // sequencing; a start while busy is ignored
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ocdu_pkg::OCDU_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ocdu_pkg::OCDU_IDLE: begin
          if (start_i) begin
            state_q <= ocdu_pkg::OCDU_PREP;
          end
        end
        ocdu_pkg::OCDU_PREP: begin
          cnt_q   <= '0;
          state_q <= ovf_d ? ocdu_pkg::OCDU_FINISH : ocdu_pkg::OCDU_DIVIDE;
        end
        ocdu_pkg::OCDU_DIVIDE: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'(`OCDU_STEPS - 1)) begin
            state_q <= ocdu_pkg::OCDU_FINISH;
          end
        end
        ocdu_pkg::OCDU_FINISH: begin
          state_q <= ocdu_pkg::OCDU_IDLE;
        end
      endcase
    end
  end

  // operand capture; dividend is remainder word above quotient word
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dvd_raw_q <= '0;
      dvs_raw_q <= '0;
      sel_q     <= ocdu_pkg::OCDU_SKIP_NONE;
    end else if (state_q == ocdu_pkg::OCDU_IDLE && start_i) begin
      dvd_raw_q <= {rem_in_i, quot_in_i};
      dvs_raw_q <= operand_i;
      sel_q     <= ocdu_pkg::ocdu_skip_t'(skip_sel_i);
    end
  end

  // magnitude datapath
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dvs_q    <= '0;
      dvd_lo_q <= '0;
      rem_q    <= '0;
      quo_q    <= '0;
      mix_q    <= 1'b0;
      ovf_q    <= 1'b0;
    end else if (state_q == ocdu_pkg::OCDU_PREP) begin
      dvs_q    <= dvs_mag;
      dvd_lo_q <= dvd_mag[`OCDU_STEPS-1:0];
      mix_q    <= dvd_raw_q[`OCDU_DVD_W-1] ^
                  dvs_raw_q[`OCDU_SIGN_BIT];
      ovf_q    <= ovf_d;
      if (ovf_d) begin
        quo_q <= `OCDU_NEG_ZERO;
        rem_q <= ovf_rem;
      end else begin
        quo_q <= '0;
        rem_q <= dvd_mag[`OCDU_WORD_W+`OCDU_STEPS-1:`OCDU_STEPS];
      end
    end else if (state_q == ocdu_pkg::OCDU_DIVIDE) begin
      dvd_lo_q <= {dvd_lo_q[`OCDU_STEPS-2:0], 1'b0};
      rem_q    <= fits ? shifted - dvs_q : shifted;
      quo_q    <= {quo_q[`OCDU_WORD_W-2:0], fits};
    end
  end

  // final sign correction and completion report
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o     <= 1'b0;
      overflow_o <= 1'b0;
      skip_o     <= 1'b0;
      quot_o     <= '0;
      rem_o      <= '0;
    end else begin
      done_o <= (state_q == ocdu_pkg::OCDU_FINISH);
      if (state_q == ocdu_pkg::OCDU_FINISH) begin
        overflow_o <= ovf_q;
        skip_o     <= skip_d;
        // zero dividend with unlike signs lands on -0 here as well
        quot_o     <= mix_q ? ~quo_q : quo_q;
        rem_o      <= mix_q ? ~rem_q : rem_q;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_q == ocdu_pkg::OCDU_IDLE) ? start_i :
                (state_q != ocdu_pkg::OCDU_FINISH);
    end
  end

  AST_DONE_ONE_CYCLE:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      done_o |=> !done_o)
    else $error("done held longer than one cycle");

  AST_NORMAL_LATENCY:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == ocdu_pkg::OCDU_PREP && !ovf_d) |-> ##31 done_o)
    else $error("normal divide did not finish in 31 cycles");

  AST_OVF_QUOT_FINAL:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (done_o && overflow_o) |->
        quot_o == (mix_q ? `OCDU_POS_ZERO : `OCDU_NEG_ZERO))
    else $error("overflow quotient has wrong zero");

  AST_OVF_QUOT_AT_SKIP:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == ocdu_pkg::OCDU_FINISH && ovf_q) |->
        quo_q == `OCDU_NEG_ZERO)
    else $error("overflow quotient not negative zero at skip test");

  AST_NO_OVF_SMALL:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == ocdu_pkg::OCDU_PREP && dvs_mag != `OCDU_POS_ZERO &&
       dvd_mag[`OCDU_DVD_W-1:`OCDU_STEPS] < {1'b0, dvs_mag}) |=> !ovf_q)
    else $error("overflow flagged for a quotient that fits");

  AST_OVF_LARGE:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == ocdu_pkg::OCDU_PREP &&
       dvd_mag[`OCDU_DVD_W-1:`OCDU_STEPS] >= {1'b0, dvs_mag})
        |-> ##2 (done_o && overflow_o))
    else $error("large dividend did not report overflow");

  AST_SKIP_ON_OVF:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (done_o && sel_q == ocdu_pkg::OCDU_SKIP_ON_OVERFLOW) |->
        skip_o == overflow_o)
    else $error("overflow skip disagrees with overflow flag");

  AST_SKIP_NO_OVF:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (done_o && sel_q == ocdu_pkg::OCDU_SKIP_WHEN_NO_OVERFLOW) |->
        skip_o == !overflow_o)
    else $error("no-overflow skip disagrees with overflow flag");

  AST_SIGN_CORRECT:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      done_o |-> (rem_o == (mix_q ? ~rem_q : rem_q)) &&
                 (quot_o == (mix_q ? ~quo_q : quo_q)))
    else $error("final sign correction wrong");

  // bounds from the divisor msb, kept apart from the overflow compare
  // so that the two can be held against each other
  always_comb begin
    dvd_top   = dvd_mag[`OCDU_DVD_W-1:`OCDU_STEPS];
    dvs_wide  = {1'b0, dvs_mag};
    // below 2^n exactly when or-ing in divisor >> 1 stays below divisor
    below_n28 = (dvd_top | (dvs_wide >> 1)) < dvs_wide;
    from_n30  = ((dvd_top >> 1) | (dvs_wide >> 1)) >= dvs_wide;
  end

  AST_NO_OVF_BELOW_N28:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == ocdu_pkg::OCDU_PREP && dvs_mag != `OCDU_POS_ZERO &&
       below_n28) |=> !ovf_q)
    else $error("overflow with dividend below divisor msb plus 29");

  AST_OVF_FROM_N30:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == ocdu_pkg::OCDU_PREP && dvs_mag != `OCDU_POS_ZERO &&
       from_n30) |=> ovf_q)
    else $error("no overflow with dividend bit at divisor msb plus 30");

  AST_SKIP_NONE:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (done_o && sel_q == ocdu_pkg::OCDU_SKIP_NONE) |-> !skip_o)
    else $error("skip taken with no skip selected");

  AST_SKIP_ALWAYS:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (done_o && sel_q == ocdu_pkg::OCDU_SKIP_ALWAYS) |-> skip_o)
    else $error("unconditional skip not taken");

  // either zero survives the final complement, so the final word tells
  AST_SKIP_ZERO_REM:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (done_o && sel_q == ocdu_pkg::OCDU_SKIP_ACC_ZERO) |->
        skip_o == (rem_o == `OCDU_POS_ZERO || rem_o == `OCDU_NEG_ZERO))
    else $error("zero remainder skip wrong");

  // a normal divide leaves a magnitude below the divisor: never negative
  AST_REM_POS_SKIP:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (done_o && !overflow_o &&
       sel_q == ocdu_pkg::OCDU_SKIP_ACC_POSITIVE) |-> skip_o)
    else $error("magnitude remainder not seen positive");

  AST_REM_NEG_SKIP:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (done_o && !overflow_o &&
       sel_q == ocdu_pkg::OCDU_SKIP_ACC_NEGATIVE) |-> !skip_o)
    else $error("magnitude remainder seen negative");

  AST_ZERO_DVD_UNLIKE:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (done_o && mix_q && dvd_mag == '0 && dvs_mag != `OCDU_POS_ZERO) |->
        (quot_o == `OCDU_NEG_ZERO && rem_o == `OCDU_NEG_ZERO))
    else $error("zero dividend with unlike signs not negative zero");

  AST_BUSY_WHILE_WORKING:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q != ocdu_pkg::OCDU_IDLE) |-> busy_o)
    else $error("busy low while a divide is in progress");

  AST_DONE_CLEARS_BUSY:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
      done_o |-> !busy_o)
    else $error("busy still high at completion");

endmodule

// ### verif/ocdu_seq_model.sv
// sequencer model that issues divide requests to the divide unit
`timescale 1ns/100ps
`include "ocdu_params.svh"

module ocdu_seq_model (
  input  wire logic               clock_i,
  output logic                    start_o,
  output logic [`OCDU_WORD_W-1:0] rem_o,
  output logic [`OCDU_WORD_W-1:0] quot_o,
  output logic [`OCDU_WORD_W-1:0] operand_o,
  output logic [2:0]              skip_sel_o
);
  initial begin
    start_o = 1'b0;
    rem_o = '0;
    quot_o = '0;
    operand_o = '0;
    skip_sel_o = 3'h0;
  end

  // dividend goes out as one pair, sign in the upper word
  // overflow skip target handling is left to the program
  task automatic issue(input logic [29:0] r, q, v, input logic [2:0] s);
    @(posedge clock_i);
    start_o <= 1'b1;
    rem_o <= r;
    quot_o <= q;
    operand_o <= v;
    skip_sel_o <= s;
  endtask

  // data only valid in the start cycle; scrambled after so stale use shows
  always @(posedge clock_i) begin
    if (start_o) begin
      start_o <= 1'b0;
      rem_o <= ~rem_o;
      quot_o <= ~quot_o;
      operand_o <= ~operand_o;
      skip_sel_o <= ~skip_sel_o;
    end
  end
endmodule

// ### verif/testbench.sv
// self-checking bench for the ones'-complement divide unit
`timescale 1ns/100ps
`include "ocdu_params.svh"

module testbench;
  logic        clock_i;
  logic        rst_n_i;
  wire         start;
  wire [29:0]  rem_in, quot_in, opnd;
  wire [2:0]   sel;
  logic        busy_o, done_o, overflow_o, skip_o;
  logic [29:0] quot_o, rem_o;
  logic [59:0] dm;
  logic [29:0] vm, qs, eq, er, r, v;
  bit          eo, es, ng, z;
  int          fail_count, total_checks, seed, k, a, b, c;

  ocdu_seq_model seq (.clock_i(clock_i), .start_o(start), .rem_o(rem_in),
    .quot_o(quot_in), .operand_o(opnd), .skip_sel_o(sel));

  ocdu_divide_unit DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .start_i(start), .rem_in_i(rem_in), .quot_in_i(quot_in),
    .operand_i(opnd), .skip_sel_i(sel), .busy_o(busy_o), .done_o(done_o),
    .overflow_o(overflow_o), .skip_o(skip_o), .quot_o(quot_o),
    .rem_o(rem_o));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task finish_test;
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [29:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: %s mismatch", $time, m);
    end
  endtask

  // reference works on magnitudes, corrects signs last
  task automatic model(input logic [29:0] rr, q, vv, input logic [2:0] s);
    ng = rr[29] ^ vv[29];
    dm = rr[29] ? ~{rr, q} : {rr, q};
    vm = vv[29] ? ~vv : vv;
    eo = (vm == 0) || ((dm / vm) >> 29 != 0);
    qs = eo ? `OCDU_NEG_ZERO : 30'(dm / vm);
    er = eo ? dm[29:0] + vm : 30'(dm % vm);
    z = (er == 0) || (&er);
    es = (s == 1) | (s == 2 & eo) | (s == 3 & !eo) | (s == 4 & z)
       | (s == 5 & !z) | (s == 6 & !er[29]) | (s == 7 & er[29]);
    eq = eo ? (ng ? `OCDU_POS_ZERO : `OCDU_NEG_ZERO) : (ng ? ~qs : qs);
    er = ng ? ~er : er;
  endtask

  // j: a second start while busy, which must be ignored
  task automatic run(input logic [29:0] rr, q, vv, input logic [2:0] s,
                     input bit j);
    int n;
    seq.issue(rr, q, vv, s);
    model(rr, q, vv, s);
    @(posedge clock_i);
    for (n = 1; n < 40; n++) begin
      @(posedge clock_i);
      if (j && n == 1) seq.start_o <= 1'b1;
      #1;
      if (n == 1) chk(busy_o, 1'b1, "busy");
      if (done_o === 1'b1) break;
    end
    // done is seen just after the edge that launches it
    chk(n, eo ? 2 : `OCDU_STEPS + 2, "latency");
    chk(overflow_o, eo, "overflow");
    chk(skip_o, es, "skip");
    chk(quot_o, eq, "quotient");
    chk(rem_o, er, "remainder");
  endtask

  initial begin
    #(12000 * 8);
    fail_count++;
    finish_test();
  end

  initial begin
    seed = 31059;
    fail_count = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    repeat (6) @(posedge clock_i);
    chk({26'h0, done_o, busy_o, overflow_o, skip_o} | quot_o | rem_o,
        30'h0, "reset");
    rst_n_i <= 1'b1;
    run(30'h0, 30'h0, 30'h3ffffffa, 3'h4, 0);
    run(30'h3fffffff, 30'h3fffffff, 30'h5, 3'h5, 0);
    run(30'h0, 30'h10000000, 30'h1, 3'h2, 0);
    run(30'h0, 30'h20000000, 30'h1, 3'h3, 0);
    run(30'h1, 30'h0, 30'h3, 3'h6, 0);
    run(30'h1, 30'h0, 30'h1, 3'h2, 0);
    run(30'h3ffffffe, 30'h3fffffff, 30'h3ffffffd, 3'h7, 0);
    run(30'h100, 30'h12345, 30'h3ffffff0, 3'h4, 0);
    run(30'h3ffffeff, 30'h3fffffff, 30'h7, 3'h5, 1);
    run(30'h5, 30'h1, 30'h0, 3'h1, 0);
    run(30'h5, 30'h1, 30'h3, 3'h4, 0);
    run(30'h0, 30'h1e, 30'h3ffffffa, 3'h0, 0);
    for (k = 0; k < 64; k++) begin
      a = $random(seed);
      b = $random(seed);
      c = $random(seed);
      r = 30'(a) >> c[4:0];
      v = 30'(b) >> c[10:6];
      if (c[5]) r = ~r;
      if (c[11]) v = ~v;
      run(r, 30'($random(seed)), v, k[2:0], k[3:0] == 3);
    end
    finish_test();
  end
endmodule
